// *** hdl/pmc_regs.sv ***
// Function
// RULE_01: Wake status clears on read, global-reset-only.
// RULE_02: Wake enable read/write, cleared only globally.
// RULE_03: Data scale and select fields read zero.
// RULE_04: No-soft-reset bit reads one, context kept.
// RULE_05: Power state codes D0, D1, D2, D3hot.
// RULE_06: Power state reads current, write adopts new.
// RULE_07: Bridge extension byte reads 00h.
// RULE_08: Power data byte reads 00h.
// RULE_09: Capability identifier byte reads 05h.
// RULE_10: Next capability pointer reads 70h.
// RULE_11: Vector masking capable bit reads zero.
// RULE_12: Wide address capable bit reads one.
// RULE_13: Capable message count reads 011.
// RULE_14: Count 000: all interrupters use message zero.
// RULE_15: Count 001: parity selects message.
// RULE_16: Count 010: interrupter n, n+4 share n.
// RULE_17: Count 011: message equals interrupter number.
// RULE_18: Codes 100, 101 map one-to-one.
// RULE_19: Messages only sent while enable bit set.
// RULE_20: Upper control byte reads zero.
// RULE_21: Message number replaces permitted low data bits.
// RULE_22: Legacy pin A reported, used without messages.
// RULE_23: Writes to read-only fields are ignored.
module pmc_regs #(
  parameter int INTR_COUNT = 8  // Interrupters served.
) (
  input  wire logic                 i_clk,           // Function clock, 40 MHz.
  input  wire logic                 i_reset_n,       // Global reset, async, active low.
  input  wire logic                 i_func_reset_n,  // Function reset, sync, active low.
  input  wire pmc_pkg::pmc_cfg_req_s i_cfg,          // Configuration access.
  output pmc_pkg::pmc_cfg_rsp_s     o_cfg,           // Configuration completion.
  input  wire logic                 i_wake_event,    // Wake event pulse.
  input  wire logic                 i_irq_valid,     // Interrupter request pulse.
  input  wire logic [2:0]           i_irq_num,       // Requesting interrupter.
  input  wire logic [15:0]          i_msg_data,      // Programmed message data.
  output pmc_pkg::pmc_msi_s         o_msi,           // Message request.
  output logic                      o_intx_req,      // Legacy pin request pulse.
  output logic [1:0]                o_power_state,   // Current power state.
  output logic                      o_wake_request,  // Wake status and enable set.
  output logic                      o_msi_enable,    // Message signalling enabled.
  output logic [2:0]                o_msg_count      // Enabled message count code.
);

  // Refused at elaboration: the interrupter number is three bits wide.
  if (INTR_COUNT < 1 || INTR_COUNT > 8) begin : g_bad_count
    $error("INTR_COUNT must lie between 1 and 8");
  end

  // Access decode.

  logic       sel_int;
  logic       sel_pm;
  logic       sel_msi;
  logic       rd;
  logic       wr;

  always_comb begin
    sel_int = i_cfg.addr[7:2] == pmc_pkg::DW_INT_LINE;
    sel_pm  = i_cfg.addr[7:2] == pmc_pkg::DW_PM_CSR;
    sel_msi = i_cfg.addr[7:2] == pmc_pkg::DW_MSI_HDR;
    rd      = i_cfg.valid & ~i_cfg.write;
    wr      = i_cfg.valid & i_cfg.write;
  end

  // Byte-lane write strobes, one per writable byte.
  logic we_int_line;
  logic we_pstate;
  logic we_wake_en;
  logic we_msi_ctrl;
  logic rd_clear;

  always_comb begin
    we_int_line = wr & sel_int & i_cfg.be[0];
    we_pstate   = wr & sel_pm & i_cfg.be[0];
    we_wake_en  = wr & sel_pm & i_cfg.be[1];
    we_msi_ctrl = wr & sel_msi & i_cfg.be[2];
    // A read that covers the status byte is the clearing access.
    rd_clear    = rd & sel_pm & i_cfg.be[1];
  end

  // Register state.

  logic [1:0] pstate_q;
  logic [7:0] int_line_q;
  logic [2:0] mme_q;
  logic       message_interrupt_enable_q;
  logic       wake_stat;
  logic       wake_en;

  // The function reset restores only the non-sticky fields. Writing D0 from
  // D3hot is an ordinary write here, so no reset is derived from it.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pstate_q <= pmc_pkg::PM_CSR_RESET[1:0];
    end else if (!i_func_reset_n) begin
      pstate_q <= pmc_pkg::PM_CSR_RESET[1:0];
    end else if (we_pstate) begin
      pstate_q <= i_cfg.wdata[pmc_pkg::PM_PSTATE_LSB +: 2];  // see RULE_05, RULE_06, RULE_04
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_line_q <= pmc_pkg::INT_LINE_RESET;
    end else if (!i_func_reset_n) begin
      int_line_q <= pmc_pkg::INT_LINE_RESET;
    end else if (we_int_line) begin
      int_line_q <= i_cfg.wdata[7:0];
    end
  end

  // Only the count and enable bits of the control byte are stored; every other
  // bit of the written byte falls away.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mme_q    <= pmc_pkg::MSI_CTRL_RESET[pmc_pkg::MC_MME_LSB +: 3];
      message_interrupt_enable_q <= pmc_pkg::MSI_CTRL_RESET[pmc_pkg::MC_EN_BIT];
    end else if (!i_func_reset_n) begin
      mme_q    <= pmc_pkg::MSI_CTRL_RESET[pmc_pkg::MC_MME_LSB +: 3];
      message_interrupt_enable_q <= pmc_pkg::MSI_CTRL_RESET[pmc_pkg::MC_EN_BIT];
    end else if (we_msi_ctrl) begin
      mme_q    <= i_cfg.wdata[16 + pmc_pkg::MC_MME_LSB +: 3];  // see RULE_18, RULE_23
      message_interrupt_enable_q <= i_cfg.wdata[16 + pmc_pkg::MC_EN_BIT];        // see RULE_19
    end
  end

  pmc_wake u_wake (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_event    (i_wake_event),
    .i_clear    (rd_clear),
    .i_en_we    (we_wake_en),
    .i_en_wdata (i_cfg.wdata[pmc_pkg::PM_WAKE_EN_BIT]),
    .o_status   (wake_stat),
    .o_enable   (wake_en),
    .o_request  (o_wake_request)
  );

  // Read-back words.

  logic [15:0] pm_csr;
  logic [15:0] msi_ctrl;
  logic [31:0] rdata;

  always_comb begin
    pm_csr                                         = '0;  // see RULE_03
    pm_csr[pmc_pkg::PM_WAKE_STAT_BIT]              = wake_stat;  // see RULE_01
    pm_csr[pmc_pkg::PM_WAKE_EN_BIT]                = wake_en;  // see RULE_02
    pm_csr[pmc_pkg::PM_NO_SOFT_BIT]                = 1'b1;  // see RULE_04
    pm_csr[pmc_pkg::PM_PSTATE_LSB +: 2]            = pstate_q;  // see RULE_06
    msi_ctrl                                       = '0;  // see RULE_20
    msi_ctrl[pmc_pkg::MC_VMASK_BIT]                = 1'b0;  // see RULE_11
    msi_ctrl[pmc_pkg::MC_WIDE_BIT]                 = 1'b1;  // see RULE_12
    msi_ctrl[pmc_pkg::MC_MME_LSB +: 3]             = mme_q;
    msi_ctrl[pmc_pkg::MC_MMC_LSB +: 3]             = pmc_pkg::MMC_VAL;  // see RULE_13
    msi_ctrl[pmc_pkg::MC_EN_BIT]                   = message_interrupt_enable_q;
  end

  // Unmapped dwords read as zero and absorb writes without effect.
  always_comb begin
    rdata = '0;
    if (sel_int) begin
      rdata = {16'h0000, pmc_pkg::INT_PIN_VAL, int_line_q};  // see RULE_22
    end else if (sel_pm) begin
      rdata = {pmc_pkg::PM_DATA_VAL, pmc_pkg::PM_BRIDGE_VAL, pm_csr};  // see RULE_07, RULE_08
    end else if (sel_msi) begin
      rdata = {msi_ctrl, pmc_pkg::MSI_NEXT_VAL, pmc_pkg::MSI_CAP_ID_VAL};  // see RULE_09, RULE_10
    end
  end

  // Disabled byte lanes read as zero so a narrow read never sees its
  // neighbours; the clear still only follows the status byte's own lane.
  logic [31:0] lane_mask;

  always_comb begin
    lane_mask = {{8{i_cfg.be[3]}}, {8{i_cfg.be[2]}}, {8{i_cfg.be[1]}}, {8{i_cfg.be[0]}}};
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cfg <= '0;
    end else begin
      o_cfg.ack   <= i_cfg.valid;
      o_cfg.rdata <= rd ? (rdata & lane_mask) : 32'h0000_0000;
    end
  end

  // Interrupt folding. Requests from interrupters beyond the configured count
  // are dropped rather than aliased onto a neighbour's message.
  logic irq_ok;

  always_comb begin
    irq_ok = i_irq_valid & ({29'h0, i_irq_num} < 32'(INTR_COUNT));
  end

  pmc_msi_map u_map (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_valid   (irq_ok),
    .i_num     (i_irq_num),
    .i_enable  (message_interrupt_enable_q),
    .i_count   (mme_q),
    .i_data    (i_msg_data),
    .o_msi     (o_msi),
    .o_intx    (o_intx_req)
  );

  // Status outputs, registered copies so every output leaves from a flop.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_power_state <= pmc_pkg::PM_CSR_RESET[1:0];
      o_msi_enable  <= pmc_pkg::MSI_CTRL_RESET[pmc_pkg::MC_EN_BIT];
      o_msg_count   <= pmc_pkg::MSI_CTRL_RESET[pmc_pkg::MC_MME_LSB +: 3];
    end else begin
      o_power_state <= pstate_q;  // see RULE_06
      o_msi_enable  <= message_interrupt_enable_q;
      o_msg_count   <= mme_q;
    end
  end

endmodule

// *** hdl/pmc_pkg.sv ***
package pmc_pkg;

  // Configuration dword indices (byte address divided by four).
  localparam logic [5:0] DW_INT_LINE = 6'h0f;  // Bytes 3Ch..3Fh.
  localparam logic [5:0] DW_PM_CSR   = 6'h11;  // Bytes 44h..47h.
  localparam logic [5:0] DW_MSI_HDR  = 6'h12;  // Bytes 48h..4Bh.

  // Byte offsets of each register.
  localparam logic [7:0] OFF_INT_LINE   = 8'h3c;
  localparam logic [7:0] OFF_INT_PIN    = 8'h3d;
  localparam logic [7:0] OFF_PM_CSR     = 8'h44;
  localparam logic [7:0] OFF_PM_BRIDGE  = 8'h46;
  localparam logic [7:0] OFF_PM_DATA    = 8'h47;
  localparam logic [7:0] OFF_MSI_CAP_ID = 8'h48;
  localparam logic [7:0] OFF_MSI_NEXT   = 8'h49;
  localparam logic [7:0] OFF_MSI_CTRL   = 8'h4a;

  // Field positions in the power control/status word.
  localparam int PM_WAKE_STAT_BIT = 15;
  localparam int PM_WAKE_EN_BIT   = 8;
  localparam int PM_NO_SOFT_BIT   = 3;
  localparam int PM_PSTATE_LSB    = 0;

  // Field positions in the message control word.
  localparam int MC_VMASK_BIT = 8;
  localparam int MC_WIDE_BIT  = 7;
  localparam int MC_MME_LSB   = 4;
  localparam int MC_MMC_LSB   = 1;
  localparam int MC_EN_BIT    = 0;

  // Fixed read values and values after reset.
  localparam logic [15:0] PM_CSR_RESET   = 16'h0008;
  localparam logic [15:0] MSI_CTRL_RESET = 16'h0086;
  localparam logic [7:0]  PM_BRIDGE_VAL  = 8'h00;
  localparam logic [7:0]  PM_DATA_VAL    = 8'h00;
  localparam logic [7:0]  MSI_CAP_ID_VAL = 8'h05;
  localparam logic [7:0]  MSI_NEXT_VAL   = 8'h70;
  localparam logic [7:0]  INT_PIN_VAL    = 8'h01;
  localparam logic [7:0]  INT_LINE_RESET = 8'hff;
  localparam logic [2:0]  MMC_VAL        = 3'h3;

  typedef enum logic [1:0] {
    PS_D0    = 2'h0,
    PS_D1    = 2'h1,
    PS_D2    = 2'h2,
    PS_D3HOT = 2'h3
  } pmc_pstate_e;

  typedef enum logic [2:0] {
    MC_ONE   = 3'h0,
    MC_TWO   = 3'h1,
    MC_FOUR  = 3'h2,
    MC_EIGHT = 3'h3,
    MC_SIXT  = 3'h4,
    MC_THRTY = 3'h5
  } pmc_count_e;

  typedef struct packed {
    logic        valid;  // One-cycle access request.
    logic        write;  // 1 write, 0 read.
    logic [7:0]  addr;   // Byte address, low two bits ignored.
    logic [3:0]  be;     // Byte enables.
    logic [31:0] wdata;  // Write data.
  } pmc_cfg_req_s;

  typedef struct packed {
    logic        ack;    // One-cycle completion.
    logic [31:0] rdata;  // Read data, zero on writes.
  } pmc_cfg_rsp_s;

  typedef struct packed {
    logic        valid;  // One-cycle message request.
    logic [4:0]  vector; // Message number.
    logic [15:0] data;   // Message data with number folded in.
  } pmc_msi_s;

endpackage

// *** hdl/pmc_wake.sv ***
module pmc_wake (
  input  wire logic i_clk,       // Function clock.
  input  wire logic i_reset_n,   // Global reset, async, active low.
  input  wire logic i_event,     // Wake event pulse.
  input  wire logic i_clear,     // Read-clear of the status bit.
  input  wire logic i_en_we,     // Enable bit write strobe.
  input  wire logic i_en_wdata,  // Enable bit write value.
  output logic      o_status,    // Sticky status bit.
  output logic      o_enable,    // Sticky enable bit.
  output logic      o_request    // Status and enable both set.
);

  // Only the global reset reaches these bits, so they outlive function resets.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_status <= 1'b0;
    end else if (i_event) begin
      o_status <= 1'b1;  // see RULE_01
    end else if (i_clear) begin
      o_status <= 1'b0;  // see RULE_01
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_enable <= 1'b0;
    end else if (i_en_we) begin
      o_enable <= i_en_wdata;  // see RULE_02
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_request <= 1'b0;
    end else begin
      o_request <= o_status & o_enable;
    end
  end

endmodule

// *** hdl/pmc_msi_map.sv ***
module pmc_msi_map (
  input  wire logic            i_clk,      // Function clock.
  input  wire logic            i_reset_n,  // Global reset, async, active low.
  input  wire logic            i_valid,    // Interrupter request pulse.
  input  wire logic [2:0]      i_num,      // Interrupter number.
  input  wire logic            i_enable,   // Message signalling enabled.
  input  wire logic [2:0]      i_count,    // Enabled message count code.
  input  wire logic [15:0]     i_data,     // Programmed message data.
  output pmc_pkg::pmc_msi_s    o_msi,      // Message request.
  output logic                 o_intx      // Legacy pin request pulse.
);

  function automatic logic [4:0] vec_of(input logic [2:0] cnt, input logic [2:0] num);
    case (cnt)
      pmc_pkg::MC_ONE:   vec_of = 5'h00;                 // see RULE_14
      pmc_pkg::MC_TWO:   vec_of = {4'h0, num[0]};        // see RULE_15
      pmc_pkg::MC_FOUR:  vec_of = {3'h0, num[1:0]};      // see RULE_16
      pmc_pkg::MC_EIGHT,
      pmc_pkg::MC_SIXT,
      pmc_pkg::MC_THRTY: vec_of = {2'h0, num};           // see RULE_17, RULE_18
      default:           vec_of = 5'h00;
    endcase
  endfunction

  function automatic logic [4:0] mask_of(input logic [2:0] cnt);
    case (cnt)
      pmc_pkg::MC_ONE:   mask_of = 5'h00;
      pmc_pkg::MC_TWO:   mask_of = 5'h01;
      pmc_pkg::MC_FOUR:  mask_of = 5'h03;
      pmc_pkg::MC_EIGHT: mask_of = 5'h07;
      pmc_pkg::MC_SIXT:  mask_of = 5'h0f;
      pmc_pkg::MC_THRTY: mask_of = 5'h1f;
      default:           mask_of = 5'h00;
    endcase
  endfunction

  logic [4:0] vec;
  logic [4:0] mask;

  always_comb begin
    vec  = vec_of(i_count, i_num);
    mask = mask_of(i_count);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_msi  <= '0;
      o_intx <= 1'b0;
    end else begin
      o_msi.valid  <= i_valid & i_enable;  // see RULE_19
      o_msi.vector <= vec;
      o_msi.data   <= {i_data[15:5], (i_data[4:0] & ~mask) | (vec & mask)};  // see RULE_21
      o_intx       <= i_valid & ~i_enable;  // see RULE_22
    end
  end

endmodule

// *** test/pmc_regs_sva.sv ***
module pmc_regs_sva #(
  parameter int INTR_COUNT = 8  // Interrupters served.
) (
  input wire logic                  i_clk,           // Clock.
  input wire logic                  i_reset_n,       // Global reset.
  input wire logic                  i_func_reset_n,  // Function reset.
  input wire pmc_pkg::pmc_cfg_req_s i_cfg,           // Access.
  input wire pmc_pkg::pmc_cfg_rsp_s o_cfg,           // Completion.
  input wire logic                  i_wake_event,    // Wake pulse.
  input wire logic                  i_irq_valid,     // Request.
  input wire logic [2:0]            i_irq_num,       // Interrupter.
  input wire logic [15:0]           i_msg_data,      // Message data.
  input wire pmc_pkg::pmc_msi_s     o_msi,           // Message out.
  input wire logic                  o_intx_req,      // Legacy pulse.
  input wire logic [1:0]            o_power_state,   // Power state.
  input wire logic                  o_wake_request,  // Wake request.
  input wire logic                  o_msi_enable,    // Enable level.
  input wire logic [2:0]            o_msg_count      // Count level.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  logic [4:0] msk;
  logic [4:0] vnum;
  logic       calm;
  logic       wr;
  logic       rd44;
  logic       rd48;
  assign msk  = (o_msg_count > 3'h5) ? 5'h00 : 5'((6'h01 << o_msg_count) - 6'h01);
  assign vnum = {2'b00, i_irq_num} & msk;
  // The level outputs lag their register by a cycle, so edges just after an update are skipped.
  assign calm = !o_cfg.ack && i_func_reset_n && i_irq_valid && (i_irq_num < INTR_COUNT);
  assign wr   = i_cfg.valid && i_cfg.write && i_func_reset_n;
  assign rd44 = i_cfg.valid && !i_cfg.write && i_cfg.addr[7:2] == 6'h11 && i_cfg.be == 4'hf;
  assign rd48 = i_cfg.valid && !i_cfg.write && i_cfg.addr[7:2] == 6'h12 && i_cfg.be == 4'hf;
  property p_rd_pm;
    rd44 |=> o_cfg.ack && o_cfg.rdata[31:16] == 16'h0 && o_cfg.rdata[14:9] == 6'h00
      && o_cfg.rdata[7:2] == 6'h02;
  endproperty
  property p_rd_id;
    rd48 |=> o_cfg.ack && o_cfg.rdata[15:0] == 16'h7005;
  endproperty
  property p_rd_ctl;
    rd48 |=> o_cfg.rdata[31:23] == 9'h001 && o_cfg.rdata[19:17] == 3'h3;
  endproperty
  property p_pstate;
    wr && i_cfg.addr[7:2] == 6'h11 && i_cfg.be[0] |=> ##1
      o_power_state == $past(i_cfg.wdata[1:0], 2);
  endproperty
  property p_ctl;
    wr && i_cfg.addr[7:2] == 6'h12 && i_cfg.be[2] |=> ##1
      o_msi_enable == $past(i_cfg.wdata[16], 2) && o_msg_count == $past(i_cfg.wdata[22:20], 2);
  endproperty
  property p_wake_off;
    wr && i_cfg.addr[7:2] == 6'h11 && i_cfg.be[1] && !i_cfg.wdata[8] |=> ##1 !o_wake_request;
  endproperty
  property p_fold;
    calm && o_msi_enable && $past(i_func_reset_n) |=> o_msi.valid && !o_intx_req
      && o_msi.vector == $past(vnum)
      && o_msi.data == (($past(i_msg_data) & ~{11'h0, $past(msk)}) | {11'h0, $past(vnum)});
  endproperty
  property p_legacy;
    calm && !o_msi_enable && $past(i_func_reset_n) |=> o_intx_req && !o_msi.valid;
  endproperty
  property p_idle;
    !i_irq_valid |=> !o_msi.valid && !o_intx_req;
  endproperty
  a_rd_pm: assert property (p_rd_pm)
    else $error("power word fixed bits wrong");
  a_rd_id: assert property (p_rd_id)
    else $error("capability header bytes wrong");
  a_rd_ctl: assert property (p_rd_ctl)
    else $error("control word fixed bits wrong");
  a_pstate: assert property (p_pstate)
    else $error("power state not adopted");
  a_ctl: assert property (p_ctl)
    else $error("control levels not adopted");
  a_wake_off: assert property (p_wake_off)
    else $error("wake request kept without enable");
  a_fold: assert property (p_fold)
    else $error("message number or data wrong");
  a_legacy: assert property (p_legacy)
    else $error("legacy request missing or message sent");
  a_idle: assert property (p_idle)
    else $error("request without cause");
  c_fold8: cover property (o_msi.valid && o_msg_count == 3'h3);
  c_intx: cover property (o_intx_req);
  c_wake: cover property (o_wake_request);
endmodule

// *** test/pmc_host.sv ***
module pmc_host (
  input  wire logic                  i_clk,  // Clock.
  input  wire pmc_pkg::pmc_cfg_rsp_s i_rsp,  // Completion.
  output pmc_pkg::pmc_cfg_req_s      o_req   // Request.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  // Released lines show the inverse of the last value, so a stale copy cannot pass.
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    @(posedge i_clk);
    o_req <= '{1'b1, w, a, be, wd};
    @(posedge i_clk);
    o_req <= '{1'b0, ~w, ~a, ~be, ~wd};
    @(posedge i_clk);
    rd = i_rsp.rdata;
    ok = i_rsp.ack;
  endtask
endmodule

// *** test/test_pci_pm_msi_capability_regs.sv ***
module test_pci_pm_msi_capability_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  i_clk = 1'b0;
  logic                  rst_n;
  logic                  frst_n;
  logic                  irq_v;
  logic [2:0]            irq_n;
  logic [15:0]           msg_d;
  logic                  wake_ev;
  pmc_pkg::pmc_cfg_req_s cfg_req;
  pmc_pkg::pmc_cfg_rsp_s cfg_rsp;
  pmc_pkg::pmc_msi_s     msi;
  logic                  intx;
  logic [1:0]            pstate;
  logic                  wake_req;
  int                    seed;
  int                    cyc = 0;
  int                    error_cnt = 0;
  int                    n_compared = 0;

  always #12.5 i_clk = ~i_clk;

  pmc_regs #(.INTR_COUNT(8)) uut (
    .i_clk(i_clk), .i_reset_n(rst_n), .i_func_reset_n(frst_n), .i_cfg(cfg_req),
    .o_cfg(cfg_rsp), .i_wake_event(wake_ev), .i_irq_valid(irq_v), .i_irq_num(irq_n),
    .i_msg_data(msg_d), .o_msi(msi), .o_intx_req(intx), .o_power_state(pstate),
    .o_wake_request(wake_req), .o_msi_enable(), .o_msg_count());
  pmc_host host (.i_clk(i_clk), .i_rsp(cfg_rsp), .o_req(cfg_req));

  function automatic logic [31:0] pm(input logic st, input logic en, input logic [1:0] ps);
    return {16'h0, st, 6'h00, en, 4'h0, 2'b10, ps};
  endfunction

  function automatic logic [21:0] fold(input logic [2:0] c, input logic [2:0] n,
                                       input logic [15:0] d);
    logic [4:0] m;
    logic [4:0] v;
    m = (c > 3'h5) ? 5'h00 : 5'((6'h01 << c) - 6'h01);
    v = {2'b00, n} & m;
    return {1'b1, v, (d & ~{11'h0, m}) | {11'h0, v}};
  endfunction

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic [31:0] d;
    logic        ok;
    host.acc(1'b0, a, 4'hf, 32'h0, d, ok);
    chk({31'h0, ok}, 32'h1, "ack");
    chk(d, exp, m);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    logic [31:0] d;
    logic        ok;
    host.acc(1'b1, a, be, v, d, ok);
    chk({31'h0, ok}, 32'h1, "ack");
  endtask

  task automatic wake();
    @(posedge i_clk);
    wake_ev <= 1'b1;
    @(posedge i_clk);
    wake_ev <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk({31'h0, wake_req}, 32'h1, "wake request");
  endtask

  // Back-to-back requests for every interrupter, each result checked the cycle after.
  task automatic burst(input logic en, input logic [2:0] c);
    logic [15:0] d;
    d = 16'($random(seed));
    for (int i = 0; i < 9; i++) begin
      @(posedge i_clk);
      irq_v <= (i < 8);
      irq_n <= 3'(i);
      msg_d <= d;
      #1;
      if (i > 0) begin
        chk({31'h0, intx}, {31'h0, !en}, "legacy");
        if (en) chk({10'h0, msi}, {10'h0, fold(c, 3'(i - 1), d)}, "message");
        else chk({31'h0, msi.valid}, 32'h0, "message off");
      end
    end
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: timeout", $time);
      end_sim();
    end
  end

  initial begin
    seed = 17;
    rst_n = 1'b0;
    frst_n = 1'b1;
    irq_v = 1'b0;
    irq_n = 3'h0;
    msg_d = 16'h0;
    wake_ev = 1'b0;
    repeat (8) @(posedge i_clk);
    rst_n <= 1'b1;
    rd(8'h44, pm(0, 0, 2'h0), "pm reset");
    rd(8'h48, 32'h0086_7005, "msi reset");
    rd(8'h3c, 32'h0000_01ff, "pin");
    wr(8'h44, 4'hf, 32'hffff_ffff);
    rd(8'h44, pm(0, 1, 2'h3), "pm ro");
    wr(8'h48, 4'hf, 32'hffff_ffff);
    rd(8'h48, 32'h00f7_7005, "msi ro");
    wr(8'h44, 4'h1, 32'h0);
    rd(8'h48, 32'h00f7_7005, "context");
    for (int s = 0; s < 4; s++) begin
      wr(8'h44, 4'h1, 32'(s));
      rd(8'h44, pm(0, 1, 2'(s)), "state");
      chk({30'h0, pstate}, 32'(s), "state out");
    end
    wake();
    @(posedge i_clk);
    frst_n <= 1'b0;
    @(posedge i_clk);
    frst_n <= 1'b1;
    rd(8'h44, pm(1, 1, 2'h0), "sticky");
    rd(8'h44, pm(0, 1, 2'h0), "read clear");
    for (int c = 0; c < 8; c++) begin
      wr(8'h48, 4'h4, {9'h0, 3'(c), 3'h0, 1'b1, 16'h0});
      burst(1'b1, 3'(c));
    end
    wr(8'h48, 4'h4, 32'h0);
    burst(1'b0, 3'h0);
    wake();
    wr(8'h44, 4'h2, 32'h0);
    rd(8'h44, pm(1, 0, 2'h0), "enable off");
    wr(8'h44, 4'h2, 32'h100);
    wake();
    @(posedge i_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    rst_n <= 1'b1;
    rd(8'h44, pm(0, 0, 2'h0), "global reset");
    end_sim();
  end
endmodule

bind pmc_regs pmc_regs_sva #(.INTR_COUNT(INTR_COUNT)) u_sva (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_func_reset_n(i_func_reset_n), .i_cfg(i_cfg),
  .o_cfg(o_cfg), .i_wake_event(i_wake_event), .i_irq_valid(i_irq_valid),
  .i_irq_num(i_irq_num), .i_msg_data(i_msg_data), .o_msi(o_msi), .o_intx_req(o_intx_req),
  .o_power_state(o_power_state), .o_wake_request(o_wake_request),
  .o_msi_enable(o_msi_enable), .o_msg_count(o_msg_count));
